// >>> design/spmc_pkg.sv
// Package with register map, mode codes, state codes and timing constants of the power mode controller.
package spmc_pkg;

	// Register indices; the byte address on the bus is four times the index.
	localparam logic [7:0] IDX_PORT1_CTRL   = 8'h1d;
	localparam logic [7:0] IDX_PORT2_CTRL   = 8'h2d;
	localparam logic [7:0] IDX_POWER_MODE   = 8'hc3;
	localparam logic [7:0] IDX_GO_SLEEP     = 8'hc4;
	localparam logic [7:0] IDX_POWER_STATUS = 8'hc5;
	localparam int         IDX_LSB          = 2;
	localparam int         IDX_MSB          = 9;
	localparam int         ADDR_WIDTH       = 12;

	// Field positions.
	localparam int         MODE_LSB         = 0;
	localparam int         MODE_MSB         = 1;
	localparam int         PLL_OFF_BIT      = 2;
	localparam int         PORT_PD_BIT      = 3;

	// Reset values.
	localparam logic [7:0] PORT_CTRL_RESET  = 8'h00;
	localparam logic [7:0] POWER_MODE_RESET = 8'h00;
	localparam logic [7:0] GO_SLEEP_RESET   = 8'h00;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

	// Global power mode encodings.
	typedef enum logic [1:0] {
		MODE_NORMAL   = 2'h0,
		MODE_ENERGY   = 2'h1,
		MODE_SOFT_PD  = 2'h2,
		MODE_SAVING   = 2'h3
	} spmc_mode_type;

	// Power states, Gray coded along normal to energy detect and normal to power saving.
	typedef enum logic [2:0] {
		ST_NORMAL    = 3'h0,
		ST_ED_AWAKE  = 3'h1,
		ST_ED_SLEEP  = 3'h3,
		ST_PS_ACTIVE = 3'h2,
		ST_PS_RX_OFF = 3'h6,
		ST_SOFT_PD   = 3'h4
	} spmc_state_type;

	// Timing: clock period, link pulse width and spacing, go-sleep step.
	localparam int CLK_PERIOD_NS       = 8;
	localparam int PULSE_WIDTH_NS      = 120;
	localparam int PULSE_WIDTH_CYCLES  = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PULSE_PERIOD_S      = 1;
	localparam int PULSE_PERIOD_CYCLES = PULSE_PERIOD_S * (1000000000 / CLK_PERIOD_NS);
	localparam int SLEEP_STEP_US       = 1000;
	localparam int SLEEP_STEP_CYCLES   = SLEEP_STEP_US * (1000 / CLK_PERIOD_NS);
	localparam int CNT_WIDTH           = 32;

endpackage

// >>> design/spmc_pulse_gen.sv
// Periodic fixed-width line pulse generator used while the link is idle.
`timescale 1ns/1ps
`default_nettype none

module spmc_pulse_gen #(
	parameter int PERIOD_CYCLES = spmc_pkg::PULSE_PERIOD_CYCLES,
	parameter int WIDTH_CYCLES  = spmc_pkg::PULSE_WIDTH_CYCLES
) (
	input  wire logic clock,     // System clock.
	input  wire logic rst_n,     // Asynchronous reset, active low.
	input  wire logic enable,    // Run the pulse train while high.
	output var  logic pulse_q    // Line pulse, high for the pulse width.
);

	logic [spmc_pkg::CNT_WIDTH-1:0] period_cnt_q;

	// Period counter restarts whenever the train is disabled, so the first pulse starts at once.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			period_cnt_q <= '0;
		end else if (!enable) begin
			period_cnt_q <= '0;
		end else if (period_cnt_q >= spmc_pkg::CNT_WIDTH'(PERIOD_CYCLES - 1)) begin
			period_cnt_q <= '0;
		end else begin
			period_cnt_q <= period_cnt_q + 1'b1;
		end
	end

	// Pulse is high during the first part of each period.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= enable && (period_cnt_q < spmc_pkg::CNT_WIDTH'(WIDTH_CYCLES));
		end
	end

endmodule

`default_nettype wire

// >>> design/spmc_switch_power_mode_controller.sv
// Top of the chip power mode controller with its AXI4-Lite register slave.
// Function
// - Two-bit mode field: 00 normal, 01 energy detect, 10 soft down, 11 saving.
// - Reset sets the mode field to 00, normal operation.
// - Normal mode keeps PLL, PHY, MAC and host interface all enabled.
// - From normal, a mode write moves directly to any other mode.
// - Power saving keeps PLL, MAC, registers; PHY transmits, unused receiver off.
// - Receiver shutdown only with auto-negotiation on, cable out, mode 11.
// - Returning line activity restores the PHY to full power in saving mode.
// - In saving mode a mode write leaves for another mode.
// - No energy longer than go-sleep setting moves energy detect into low power.
// - Low power keeps only the energy detector; energy returns to normal power.
// - Energy detect without link sends 120 ns pulses once per second.
// - Power mode bit 2 set disables the PLL.
// - Soft down stops PLL, PHY, MAC, keeps registers; writing 00 returns normal.
// - Port control bit 3 powers down that PHY port regardless of mode.
// - Active-low power-down pin powers the whole chip down.
`timescale 1ns/1ps
`default_nettype none

module spmc_switch_power_mode_controller #(
	parameter int PULSE_PERIOD_CYCLES = spmc_pkg::PULSE_PERIOD_CYCLES,
	parameter int SLEEP_STEP_CYCLES   = spmc_pkg::SLEEP_STEP_CYCLES
) (
	input  wire logic                           clock,             // System clock, 125 MHz.
	input  wire logic                           rst_n,             // Asynchronous reset, active low.
	input  wire logic [spmc_pkg::ADDR_WIDTH-1:0] s_axi_awaddr,     // Write address.
	input  wire logic                           s_axi_awvalid,     // Write address valid.
	output var  logic                           s_axi_awready,     // Write address ready.
	input  wire logic [31:0]                    s_axi_wdata,       // Write data.
	input  wire logic [3:0]                     s_axi_wstrb,       // Write byte strobes.
	input  wire logic                           s_axi_wvalid,      // Write data valid.
	output var  logic                           s_axi_wready,      // Write data ready.
	output var  logic [1:0]                     s_axi_bresp,       // Write response.
	output var  logic                           s_axi_bvalid,      // Write response valid.
	input  wire logic                           s_axi_bready,      // Write response ready.
	input  wire logic [spmc_pkg::ADDR_WIDTH-1:0] s_axi_araddr,     // Read address.
	input  wire logic                           s_axi_arvalid,     // Read address valid.
	output var  logic                           s_axi_arready,     // Read address ready.
	output var  logic [31:0]                    s_axi_rdata,       // Read data.
	output var  logic [1:0]                     s_axi_rresp,       // Read response.
	output var  logic                           s_axi_rvalid,      // Read data valid.
	input  wire logic                           s_axi_rready,      // Read data ready.
	input  wire logic                           chip_power_down_n, // Hardware power-down pin, active low.
	input  wire logic                           autoneg_en,        // Auto-negotiation enabled.
	input  wire logic                           link_up,           // PHY link is up.
	input  wire logic                           cable_energy,      // Energy seen on the cable.
	output var  logic                           pll_clk_en_q,      // Internal PLL clocks enabled.
	output var  logic                           phy_tx_en_q,       // PHY transmitter powered.
	output var  logic                           phy_rx_en_q,       // PHY full receiver powered.
	output var  logic                           energy_det_en_q,   // Receiver energy detector powered.
	output var  logic                           mac_en_q,          // MAC powered.
	output var  logic                           host_if_en_q,      // Host interface enabled.
	output var  logic                           port1_phy_pd_q,    // Port 1 PHY powered down.
	output var  logic                           port2_phy_pd_q,    // Port 2 PHY powered down.
	output var  logic                           line_pulse_q       // Idle link pulse on the line.
);

	logic [7:0]                     port1_ctrl_q;
	logic [7:0]                     port2_ctrl_q;
	logic [7:0]                     power_mode_q;
	logic [7:0]                     go_sleep_q;
	logic                           aw_held_q;
	logic                           w_held_q;
	logic [7:0]                     aw_index_q;
	logic                           aw_mapped_q;
	logic [7:0]                     wdata_q;
	logic                           wstrb0_q;
	logic [spmc_pkg::CNT_WIDTH-1:0] step_cnt_q;
	logic [8:0]                     sleep_steps_q;
	logic                           sleep_due;
	logic                           pulse_en_q;
	logic                           do_write;
	spmc_pkg::spmc_state_type       state_q;
	spmc_pkg::spmc_mode_type        mode;

	// Byte address to register index; the bits below a word are ignored.
	function automatic logic [7:0] reg_index(input logic [spmc_pkg::ADDR_WIDTH-1:0] addr);
		reg_index = addr[spmc_pkg::IDX_MSB:spmc_pkg::IDX_LSB];
	endfunction

	// True for any index that holds a register.
	function automatic logic reg_mapped(input logic [7:0] idx);
		reg_mapped = (idx == spmc_pkg::IDX_PORT1_CTRL) || (idx == spmc_pkg::IDX_PORT2_CTRL) ||
			(idx == spmc_pkg::IDX_POWER_MODE) || (idx == spmc_pkg::IDX_GO_SLEEP) ||
			(idx == spmc_pkg::IDX_POWER_STATUS) || 1'b0;
	endfunction

	assign mode     = spmc_pkg::spmc_mode_type'(power_mode_q[spmc_pkg::MODE_MSB:spmc_pkg::MODE_LSB]);
	assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

	// Write address and data are captured separately, in either order, and released after the response.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			aw_held_q     <= 1'b0;
			w_held_q      <= 1'b0;
			aw_index_q    <= 8'h00;
			aw_mapped_q   <= 1'b0;
			wdata_q       <= 8'h00;
			wstrb0_q      <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_q     <= 1'b1;
				aw_index_q    <= reg_index(s_axi_awaddr);
				aw_mapped_q   <= reg_mapped(reg_index(s_axi_awaddr));
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_q     <= 1'b1;
				wdata_q      <= s_axi_wdata[7:0];
				wstrb0_q     <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				aw_held_q     <= 1'b0;
				w_held_q      <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Write response; an unmapped address answers SLVERR and changes nothing.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= spmc_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= aw_mapped_q ? spmc_pkg::RESP_OKAY : spmc_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Register storage; the bus stays alive in every mode so software can always write the mode back.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			port1_ctrl_q <= spmc_pkg::PORT_CTRL_RESET;
			port2_ctrl_q <= spmc_pkg::PORT_CTRL_RESET;
			power_mode_q <= spmc_pkg::POWER_MODE_RESET;
			go_sleep_q   <= spmc_pkg::GO_SLEEP_RESET;
		end else if (do_write && wstrb0_q) begin
			unique case (aw_index_q)
				spmc_pkg::IDX_PORT1_CTRL: port1_ctrl_q <= wdata_q;
				spmc_pkg::IDX_PORT2_CTRL: port2_ctrl_q <= wdata_q;
				spmc_pkg::IDX_POWER_MODE: power_mode_q <= wdata_q;
				spmc_pkg::IDX_GO_SLEEP:   go_sleep_q   <= wdata_q;
				default: begin
				end
			endcase
		end
	end

	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= spmc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= reg_mapped(reg_index(s_axi_araddr)) ? spmc_pkg::RESP_OKAY : spmc_pkg::RESP_SLVERR;
			unique case (reg_index(s_axi_araddr))
				spmc_pkg::IDX_PORT1_CTRL:   s_axi_rdata <= {24'h000000, port1_ctrl_q};
				spmc_pkg::IDX_PORT2_CTRL:   s_axi_rdata <= {24'h000000, port2_ctrl_q};
				spmc_pkg::IDX_POWER_MODE:   s_axi_rdata <= {24'h000000, power_mode_q};
				spmc_pkg::IDX_GO_SLEEP:     s_axi_rdata <= {24'h000000, go_sleep_q};
				spmc_pkg::IDX_POWER_STATUS: s_axi_rdata <= {28'h0000000, !chip_power_down_n, state_q};
				default:                    s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Idle timer in steps; any cable energy or leaving the awake state restarts it.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			step_cnt_q    <= '0;
			sleep_steps_q <= 9'h000;
		end else if (cable_energy || state_q != spmc_pkg::ST_ED_AWAKE) begin
			step_cnt_q    <= '0;
			sleep_steps_q <= 9'h000;
		end else if (step_cnt_q >= spmc_pkg::CNT_WIDTH'(SLEEP_STEP_CYCLES - 1)) begin
			step_cnt_q <= '0;
			if (!sleep_due) begin
				sleep_steps_q <= sleep_steps_q + 9'h001;
			end
		end else begin
			step_cnt_q <= step_cnt_q + 1'b1;
		end
	end

	// The quiet time must exceed the setting, hence strictly greater.
	assign sleep_due = sleep_steps_q > {1'b0, go_sleep_q};

	// Power state follows the mode field; the sub-states track line energy.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= spmc_pkg::ST_NORMAL;
		end else begin
			unique case (mode)
				spmc_pkg::MODE_NORMAL: begin
					state_q <= spmc_pkg::ST_NORMAL;
				end
				spmc_pkg::MODE_SOFT_PD: begin
					state_q <= spmc_pkg::ST_SOFT_PD;
				end
				spmc_pkg::MODE_SAVING: begin
					if (cable_energy || link_up) begin
						state_q <= spmc_pkg::ST_PS_ACTIVE;
					end else if (autoneg_en || state_q == spmc_pkg::ST_PS_RX_OFF) begin
						state_q <= spmc_pkg::ST_PS_RX_OFF;
					end else begin
						state_q <= spmc_pkg::ST_PS_ACTIVE;
					end
				end
				spmc_pkg::MODE_ENERGY: begin
					if (cable_energy) begin
						state_q <= spmc_pkg::ST_ED_AWAKE;
					end else if (state_q == spmc_pkg::ST_ED_SLEEP || (state_q == spmc_pkg::ST_ED_AWAKE && sleep_due)) begin
						state_q <= spmc_pkg::ST_ED_SLEEP;
					end else begin
						state_q <= spmc_pkg::ST_ED_AWAKE;
					end
				end
			endcase
		end
	end

	// Block enables per state; the power-down pin overrides every state.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pll_clk_en_q    <= 1'b0;
			phy_tx_en_q     <= 1'b0;
			phy_rx_en_q     <= 1'b0;
			energy_det_en_q <= 1'b0;
			mac_en_q        <= 1'b0;
			host_if_en_q    <= 1'b0;
		end else if (!chip_power_down_n) begin
			pll_clk_en_q    <= 1'b0;
			phy_tx_en_q     <= 1'b0;
			phy_rx_en_q     <= 1'b0;
			energy_det_en_q <= 1'b0;
			mac_en_q        <= 1'b0;
			host_if_en_q    <= 1'b0;
		end else begin
			unique case (state_q)
				spmc_pkg::ST_NORMAL, spmc_pkg::ST_PS_ACTIVE: begin
					pll_clk_en_q    <= !power_mode_q[spmc_pkg::PLL_OFF_BIT];
					phy_tx_en_q     <= 1'b1;
					phy_rx_en_q     <= 1'b1;
					energy_det_en_q <= 1'b1;
					mac_en_q        <= 1'b1;
					host_if_en_q    <= 1'b1;
				end
				spmc_pkg::ST_PS_RX_OFF: begin
					pll_clk_en_q    <= !power_mode_q[spmc_pkg::PLL_OFF_BIT];
					phy_tx_en_q     <= 1'b1;
					phy_rx_en_q     <= 1'b0;
					energy_det_en_q <= 1'b1;
					mac_en_q        <= 1'b1;
					host_if_en_q    <= 1'b1;
				end
				spmc_pkg::ST_ED_AWAKE: begin
					pll_clk_en_q    <= !power_mode_q[spmc_pkg::PLL_OFF_BIT];
					phy_tx_en_q     <= 1'b1;
					phy_rx_en_q     <= 1'b1;
					energy_det_en_q <= 1'b1;
					mac_en_q        <= 1'b0;
					host_if_en_q    <= 1'b0;
				end
				spmc_pkg::ST_ED_SLEEP: begin
					pll_clk_en_q    <= 1'b0;
					phy_tx_en_q     <= 1'b0;
					phy_rx_en_q     <= 1'b0;
					energy_det_en_q <= 1'b1;
					mac_en_q        <= 1'b0;
					host_if_en_q    <= 1'b0;
				end
				spmc_pkg::ST_SOFT_PD: begin
					pll_clk_en_q    <= 1'b0;
					phy_tx_en_q     <= 1'b0;
					phy_rx_en_q     <= 1'b0;
					energy_det_en_q <= 1'b0;
					mac_en_q        <= 1'b0;
					host_if_en_q    <= 1'b0;
				end
				default: begin
					pll_clk_en_q    <= 1'b0;
					phy_tx_en_q     <= 1'b0;
					phy_rx_en_q     <= 1'b0;
					energy_det_en_q <= 1'b0;
					mac_en_q        <= 1'b0;
					host_if_en_q    <= 1'b0;
				end
			endcase
		end
	end

	// Per-port power down is independent of the global mode.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			port1_phy_pd_q <= 1'b0;
			port2_phy_pd_q <= 1'b0;
		end else begin
			port1_phy_pd_q <= port1_ctrl_q[spmc_pkg::PORT_PD_BIT] || !chip_power_down_n;
			port2_phy_pd_q <= port2_ctrl_q[spmc_pkg::PORT_PD_BIT] || !chip_power_down_n;
		end
	end

	// Pulses only while in energy detect without link; registered to keep the enable glitch free.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pulse_en_q <= 1'b0;
		end else begin
			pulse_en_q <= chip_power_down_n && !link_up && (mode == spmc_pkg::MODE_ENERGY);
		end
	end

	spmc_pulse_gen #(
		.PERIOD_CYCLES (PULSE_PERIOD_CYCLES),
		.WIDTH_CYCLES  (spmc_pkg::PULSE_WIDTH_CYCLES)
	) u_pulse (
		.clock   (clock),
		.rst_n   (rst_n),
		.enable  (pulse_en_q),
		.pulse_q (line_pulse_q)
	);

endmodule

`default_nettype wire

// >>> verification/spmc_asserts.sv
// Port-level checker of the power mode controller.
`timescale 1ns/1ps
`default_nettype none

module spmc_asserts (
	input wire logic clock,             // System clock.
	input wire logic rst_n,             // Reset, active low.
	input wire logic chip_power_down_n, // Power-down pin, active low.
	input wire logic autoneg_en,        // Auto-negotiation on.
	input wire logic link_up,           // Link state.
	input wire logic cable_energy,      // Cable energy seen.
	input wire logic pll_clk_en_q,      // PLL clocks on.
	input wire logic phy_tx_en_q,       // PHY transmitter on.
	input wire logic phy_rx_en_q,       // PHY receiver on.
	input wire logic energy_det_en_q,   // Energy detector on.
	input wire logic mac_en_q,          // MAC on.
	input wire logic host_if_en_q,      // Host interface on.
	input wire logic port1_phy_pd_q,    // Port 1 powered down.
	input wire logic line_pulse_q       // Idle line pulse.
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// Three low samples of the pin leave PLL, transmitter and MAC off and port 1 powered down.
	sequence s_pin_low; !chip_power_down_n [*3]; endsequence
	property p_pin_down; s_pin_low |-> !pll_clk_en_q && !phy_tx_en_q && !mac_en_q && port1_phy_pd_q; endproperty
	a_pin_down: assert property (p_pin_down) else $error("pin power-down not obeyed");

	// The receiver alone drops only with auto-negotiation on and no link.
	property p_rx_cause; $fell(phy_rx_en_q) && phy_tx_en_q |-> $past(autoneg_en, 2) && !$past(link_up, 2) && mac_en_q;
	endproperty
	a_rx_cause: assert property (p_rx_cause) else $error("receiver shut down without cause");

	// Energy on the line brings the receiver back within three cycles.
	property p_rx_back; phy_tx_en_q && !phy_rx_en_q && cable_energy && chip_power_down_n |-> ##[1:3] phy_rx_en_q;
	endproperty
	a_rx_back: assert property (p_rx_back) else $error("receiver not restored");

	// In the low power state only the energy detector stays on.
	property p_sleep_only; energy_det_en_q && !phy_tx_en_q |-> !phy_rx_en_q && !mac_en_q && !host_if_en_q && !pll_clk_en_q;
	endproperty
	a_sleep_only: assert property (p_sleep_only) else $error("low power state leaves blocks on");

	// Sleep is entered only after a quiet line.
	property p_sleep_quiet; $fell(phy_tx_en_q) && energy_det_en_q && !$past(mac_en_q) |-> !$past(cable_energy, 2);
	endproperty
	a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep entered with energy");

	// A running MAC always has the host side and transmitter with it.
	property p_mac_host; mac_en_q |-> host_if_en_q && phy_tx_en_q; endproperty
	a_mac_host: assert property (p_mac_host) else $error("MAC on without host or transmitter");

	// Host interface goes down together with the MAC.
	property p_host_off; !mac_en_q |-> !host_if_en_q; endproperty
	a_host_off: assert property (p_host_off) else $error("host interface on with MAC off");

	// A line pulse is high for exactly fifteen cycles.
	sequence s_pulse; line_pulse_q [*8] ##1 line_pulse_q [*7]; endsequence
	property p_pulse; $rose(line_pulse_q) |-> s_pulse ##1 !line_pulse_q; endproperty
	a_pulse: assert property (p_pulse) else $error("line pulse width wrong");
endmodule

bind spmc_switch_power_mode_controller spmc_asserts u_asserts (.clock(clock), .rst_n(rst_n),
	.chip_power_down_n(chip_power_down_n), .autoneg_en(autoneg_en), .link_up(link_up),
	.cable_energy(cable_energy), .pll_clk_en_q(pll_clk_en_q), .phy_tx_en_q(phy_tx_en_q),
	.phy_rx_en_q(phy_rx_en_q), .energy_det_en_q(energy_det_en_q), .mac_en_q(mac_en_q),
	.host_if_en_q(host_if_en_q), .port1_phy_pd_q(port1_phy_pd_q), .line_pulse_q(line_pulse_q));
`default_nettype wire

// >>> verification/spmc_host_model.sv
// Host processor model: an AXI4-Lite master for the control registers.
`timescale 1ns/1ps
`default_nettype none

module spmc_host_model (
	input  wire logic        clock,   // System clock.
	output var  logic [11:0] awaddr,  // Write address.
	output var  logic        awvalid, // Write address valid.
	input  wire logic        awready, // Write address ready.
	output var  logic [31:0] wdata,   // Write data.
	output var  logic [3:0]  wstrb,   // Write strobes.
	output var  logic        wvalid,  // Write data valid.
	input  wire logic        wready,  // Write data ready.
	input  wire logic        bvalid,  // Write response valid.
	output var  logic        bready,  // Write response ready.
	output var  logic [11:0] araddr,  // Read address.
	output var  logic        arvalid, // Read address valid.
	input  wire logic        arready, // Read address ready.
	input  wire logic        rvalid,  // Read data valid.
	output var  logic        rready   // Read data ready.
);
	// Idle bus at time zero.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end

	// Both write channels are offered together and each is dropped when taken.
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		fork
			begin
				do @(posedge clock); while (!awready);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge clock); while (!wready);
				wvalid <= 1'b0;
			end
		join
		do @(posedge clock); while (!bvalid);
		bready <= 1'b0;
	endtask

	// The opening edge keeps a ready release and a new raise out of one time step.
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clock); while (!rvalid);
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench of the power mode controller.
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int PER = 200;
	localparam logic [11:0] A_P1 = {2'h0, spmc_pkg::IDX_PORT1_CTRL, 2'h0};
	localparam logic [11:0] A_P2 = {2'h0, spmc_pkg::IDX_PORT2_CTRL, 2'h0};
	localparam logic [11:0] A_MD = {2'h0, spmc_pkg::IDX_POWER_MODE, 2'h0};
	localparam logic [11:0] A_GS = {2'h0, spmc_pkg::IDX_GO_SLEEP, 2'h0};
	localparam logic [11:0] A_ST = {2'h0, spmc_pkg::IDX_POWER_STATUS, 2'h0};
	localparam logic [11:0] A_UN = 12'h000;
	localparam logic [11:0] REGS [5] = '{A_P1, A_P2, A_MD, A_GS, A_ST};
	localparam logic [6:0]  MX [4] = '{7'h7c, 7'h70, 7'h00, 7'h7c};
	localparam logic [2:0]  SX [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
	logic clock = 1'b0, rst_n = 1'b0, chip_power_down_n = 1'b1;
	logic autoneg_en = 1'b1, link_up = 1'b1, cable_energy = 1'b1;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic pll, tx, rx, ed, mac, hif, pd1, pd2, pulse;
	logic [6:0] en;
	logic [7:0] d;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int fail_count = 0, compares = 0, cycles = 0, n, c;

	assign en = {pll, tx, rx, mac, hif, pd1, pd2};
	// A short pulse period keeps the run small.
	always #4 clock = ~clock;

	spmc_switch_power_mode_controller #(.PULSE_PERIOD_CYCLES(PER), .SLEEP_STEP_CYCLES(10)) DUT (
		.clock(clock), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_power_down_n(chip_power_down_n),
		.autoneg_en(autoneg_en), .link_up(link_up), .cable_energy(cable_energy), .pll_clk_en_q(pll),
		.phy_tx_en_q(tx), .phy_rx_en_q(rx), .energy_det_en_q(ed), .mac_en_q(mac), .host_if_en_q(hif),
		.port1_phy_pd_q(pd1), .port2_phy_pd_q(pd2), .line_pulse_q(pulse));

	spmc_host_model host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic results();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Answers leave the note queues in request order, at their handshake edge.
	always @(posedge clock) begin
		if (rvalid && rready) chk("read", rq.pop_front(), {rresp, rdata});
		if (bvalid && bready) chk("bresp", bq.pop_front(), bresp);
	end

	// A hang is cut short well beyond the expected run length.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s = 4'hf);
		bq.push_back(a == A_UN ? spmc_pkg::RESP_SLVERR : spmc_pkg::RESP_OKAY);
		host.wr(a, v, s);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] v);
		rq.push_back({a == A_UN ? spmc_pkg::RESP_SLVERR : spmc_pkg::RESP_OKAY, 24'h0, v});
		host.rd(a);
	endtask

	// Enables are compared once a write or line change has landed.
	task automatic ex(input logic [6:0] e);
		repeat (4) @(posedge clock);
		#1;
		chk("enables", e, en);
	endtask

	task automatic lin(input logic a, input logic l, input logic e);
		@(posedge clock);
		autoneg_en <= a;
		link_up <= l;
		cable_energy <= e;
	endtask

	task automatic wt(input logic v, output int k);
		k = 0;
		do begin
			@(posedge clock);
			k++;
		end while (pulse !== v && k < 500);
	endtask

	task automatic reset();
		rst_n <= 1'b0;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
	endtask

	initial begin
		void'($urandom(29337));
		reset();
		for (int i = 0; i < 5; i++) rd(REGS[i], 8'h00);
		ex(7'h7c);
		d = 8'($urandom());
		wr(A_GS, d);
		rd(A_GS, d);
		wr(A_GS, ~d, 4'he);
		rd(A_GS, d);
		wr(A_UN, 8'h12);
		rd(A_UN, 8'h00);
		wr(A_P1, 8'h08);
		ex(7'h7e);
		wr(A_P1, 8'h00);
		wr(A_P2, 8'h08);
		ex(7'h7d);
		wr(A_P2, 8'h00);
		wr(A_MD, 8'h04);
		ex(7'h3c);
		// Every mode is entered from normal and left again with 00.
		for (int m = 1; m < 4; m++) begin
			wr(A_MD, 8'(m));
			ex(MX[m]);
			rd(A_ST, {5'h0, SX[m]});
			rd(A_MD, 8'(m));
			wr(A_MD, 8'h00);
			ex(7'h7c);
		end
		// Saving mode shuts the receiver only for an unplugged cable under auto-negotiation.
		lin(1'b0, 1'b0, 1'b0);
		wr(A_MD, 8'h03);
		ex(7'h7c);
		lin(1'b1, 1'b0, 1'b0);
		ex(7'h6c);
		lin(1'b1, 1'b0, 1'b1);
		ex(7'h7c);
		wr(A_MD, 8'h01);
		ex(7'h70);
		wt(1'b0, n);
		wt(1'b1, n);
		wt(1'b0, n);
		chk("width", spmc_pkg::PULSE_WIDTH_CYCLES, n);
		wt(1'b1, c);
		chk("period", PER, n + c);
		// Quiet line: sleep only after the go-sleep time, wake on energy.
		wr(A_GS, 8'h02);
		lin(1'b1, 1'b0, 1'b0);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (en !== 7'h00 && n < 100);
		chk("sleep", 1'b1, n > 20 && n < 40);
		chk("detector", 1'b1, ed);
		lin(1'b1, 1'b0, 1'b1);
		ex(7'h70);
		wr(A_MD, 8'h05);
		ex(7'h30);
		// Leave energy detect between pulses so no pulse is cut short.
		wt(1'b1, n);
		repeat (20) @(posedge clock);
		lin(1'b1, 1'b1, 1'b1);
		wr(A_MD, 8'h00);
		ex(7'h7c);
		@(posedge clock);
		chip_power_down_n <= 1'b0;
		ex(7'h03);
		rd(A_ST, 8'h08);
		rd(A_GS, 8'h02);
		@(posedge clock);
		chip_power_down_n <= 1'b1;
		ex(7'h7c);
		wr(A_MD, 8'h03);
		reset();
		rd(A_MD, 8'h00);
		results();
	end
endmodule
`default_nettype wire
